// File: hdl/tsd_top.v
// tilt and shake detector: register bank, periodic readings, facing and shake logic
// assumes raw signed axis samples from the front end on clk_sys, scl/sda from pins
`timescale 1ns/1ns
`default_nettype none
`include "tsd_regs.vh"
module tsd_top (
	// clock and reset
	input  wire       clk_sys,
	input  wire       rst_n,
	// front-end samples, signed, same clock domain
	input  wire [7:0] x_sample,
	input  wire [7:0] y_sample,
	// i2c pins
	input  wire       scl_in,
	input  wire       sda_in,
	output wire       sda_oe_n,
	output wire       sda_out,
	// interrupt pin and power state
	output reg        irq_ff,
	output reg        low_power_ff
);
	// ****************************************************************
	// reset and pin synchronisers
	// ****************************************************************
	reg        rst_a_ff;
	reg        rst_b_ff;
	reg  [1:0] scl_sync_ff;
	reg  [1:0] sda_sync_ff;
	reg        sda_zero_ff;
	wire       sda_oe_n_i;
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rst_a_ff <= 1'b0;
			rst_b_ff <= 1'b0;
		end else begin
			rst_a_ff <= 1'b1;
			rst_b_ff <= rst_a_ff;
		end
	end
	always @(posedge clk_sys or negedge rst_b_ff) begin
		if (!rst_b_ff) begin
			scl_sync_ff <= 2'b11;
			sda_sync_ff <= 2'b11;
			sda_zero_ff <= 1'b0;
		end else begin
			scl_sync_ff <= {scl_sync_ff[0], scl_in};
			sda_sync_ff <= {sda_sync_ff[0], sda_in};
			sda_zero_ff <= 1'b0;
		end
	end
	assign sda_oe_n = sda_oe_n_i;
	assign sda_out  = sda_zero_ff;
	// ****************************************************************
	// serial slave
	// ****************************************************************
	wire [7:0] ptr;
	wire       wr_stb;
	wire [7:0] wr_data;
	wire       rd_stb;
	reg  [7:0] rd_data;
	tsd_i2c_slave u_slave (
		.clk_sys     (clk_sys),
		.rst_n_sync  (rst_b_ff),
		.scl_s       (scl_sync_ff[1]),
		.sda_s       (sda_sync_ff[1]),
		.sda_oe_n_ff (sda_oe_n_i),
		.ptr_ff      (ptr),
		.wr_stb_ff   (wr_stb),
		.wr_data_ff  (wr_data),
		.rd_stb_ff   (rd_stb),
		.rd_data     (rd_data)
	);
	// ****************************************************************
	// register bank
	// ****************************************************************
	reg  [7:0] ctrl_ff; // [R1]
	reg  [7:0] x_accel_value_ff;
	reg  [7:0] y_accel_value_ff;
	reg  [1:0] jolt_direction_ff;
	reg        weak_ff;
	reg  [1:0] instant_facing_ff;
	reg  [1:0] filt_facing_ff;
	reg        flag_ff;
	wire [7:0] status_w = {flag_ff, jolt_direction_ff, weak_ff,
		instant_facing_ff, filt_facing_ff}; // [R3]
	wire       reversal_mode     = ctrl_ff[`TSD_CT_MODE];
	wire [1:0] jolt_threshold    = ctrl_ff[`TSD_CT_TH_HI:`TSD_CT_TH_LO];
	wire [1:0] jolt_window_count = ctrl_ff[`TSD_CT_WIN_HI:`TSD_CT_WIN_LO];
	wire [1:0] facing_settle_count = ctrl_ff[`TSD_CT_SET_HI:`TSD_CT_SET_LO];
	always @* begin
		case (ptr)
		`TSD_ADR_X:      rd_data = x_accel_value_ff; // [R2]
		`TSD_ADR_Y:      rd_data = y_accel_value_ff; // [R2]
		`TSD_ADR_STATUS: rd_data = status_w;
		default:         rd_data = 8'h00; // [R23]
		endcase
	end
	wire status_read = rd_stb & (ptr == `TSD_ADR_STATUS); // [R16]
	always @(posedge clk_sys or negedge rst_b_ff) begin
		if (!rst_b_ff) begin
			ctrl_ff      <= `TSD_CTRL_RESET; // [R24]
			low_power_ff <= 1'b0;
		end else begin
			if (wr_stb && ptr == `TSD_ADR_CTRL)
				ctrl_ff <= wr_data; // [R19] [R23]
			low_power_ff <= ctrl_ff[`TSD_CT_LOWPWR]; // [R20]
		end
	end
	// ****************************************************************
	// reading tick
	// ****************************************************************
	reg  [16:0] tick_cnt_ff;
	reg         tick_ff;
	always @(posedge clk_sys or negedge rst_b_ff) begin
		if (!rst_b_ff) begin
			tick_cnt_ff <= 17'h00000;
			tick_ff     <= 1'b0;
		end else if (ctrl_ff[`TSD_CT_LOWPWR]) begin
			tick_cnt_ff <= 17'h00000; // [R20]
			tick_ff     <= 1'b0;
		end else if (tick_cnt_ff == `TSD_READ_LAST) begin
			tick_cnt_ff <= 17'h00000; // [R7]
			tick_ff     <= 1'b1;
		end else begin
			tick_cnt_ff <= tick_cnt_ff + 17'h00001;
			tick_ff     <= 1'b0;
		end
	end
	// ****************************************************************
	// facing
	// ****************************************************************
	wire signed [8:0] xs = {x_sample[7], x_sample};
	wire signed [8:0] ys = {y_sample[7], y_sample};
	wire [8:0] xmag = xs[8] ? 9'h000 - xs : xs;
	wire [8:0] ymag = ys[8] ? 9'h000 - ys : ys;
	wire [8:0] big  = (xmag > ymag) ? xmag : ymag;
	wire       valid = big > {1'b0, `TSD_VALID_MAG}; // [R5]
	wire signed [8:0] dif = xs - ys;
	wire signed [8:0] sum = xs + ys;
	reg  [1:0] facing;
	always @* begin
		// quadrant by the two diagonals
		case ({dif[8], sum[8]})
		2'b01:   facing = 2'b00; // [R4] [R5]
		2'b00:   facing = 2'b01;
		2'b10:   facing = 2'b10;
		default: facing = 2'b11;
		endcase
	end
	reg  [7:0] settle_ff;
	reg  [1:0] cand_ff;
	wire [7:0] settle_goal = 8'h10 << facing_settle_count; // [R6]
	reg        facing_chg_ff;
	always @(posedge clk_sys or negedge rst_b_ff) begin
		if (!rst_b_ff) begin
			x_accel_value_ff  <= 8'h00;
			y_accel_value_ff  <= 8'h00;
			weak_ff           <= 1'b0;
			instant_facing_ff <= 2'b00;
			filt_facing_ff    <= 2'b00;
			settle_ff         <= 8'h00;
			cand_ff           <= 2'b00;
			facing_chg_ff     <= 1'b0;
		end else begin
			facing_chg_ff <= 1'b0;
			if (tick_ff) begin
				x_accel_value_ff <= x_sample;
				y_accel_value_ff <= y_sample;
				weak_ff <= ~valid; // [R9]
				if (valid) begin
					instant_facing_ff <= facing; // [R8]
					if (facing == filt_facing_ff) begin
						settle_ff <= 8'h00;
					end else if (facing != cand_ff || settle_ff == 8'h00) begin
						cand_ff   <= facing;
						settle_ff <= 8'h01;
						if (settle_goal == 8'h01) begin
							filt_facing_ff <= facing;
							facing_chg_ff  <= 1'b1;
						end
					end else if (settle_ff + 8'h01 == settle_goal) begin
						filt_facing_ff <= facing; // [R6]
						facing_chg_ff  <= 1'b1; // [R15]
						settle_ff      <= 8'h00;
					end else begin
						settle_ff <= settle_ff + 8'h01;
					end
				end else begin
					settle_ff <= 8'h00;
				end
			end
		end
	end
	// ****************************************************************
	// shake
	// ****************************************************************
	wire [7:0] perp    = filt_facing_ff[0] ? x_sample : y_sample; // [R10]
	wire [8:0] pmag    = filt_facing_ff[0] ? xmag : ymag;
	wire [8:0] thr     = {1'b0, `TSD_ONE_G} * ({7'h00, jolt_threshold} + 9'h001) >> 1; // [R11]
	wire       over    = pmag > thr;
	reg        armed_ff;
	reg        first_neg_ff;
	reg  [7:0] win_ff;
	wire [7:0] win_goal = 8'h10 << jolt_window_count; // [R13]
	reg        shake_hit_ff;
	always @(posedge clk_sys or negedge rst_b_ff) begin
		if (!rst_b_ff) begin
			armed_ff          <= 1'b0;
			first_neg_ff      <= 1'b0;
			win_ff            <= 8'h00;
			jolt_direction_ff <= 2'b00;
			shake_hit_ff      <= 1'b0;
		end else begin
			shake_hit_ff <= 1'b0;
			if (status_read)
				jolt_direction_ff <= 2'b00;
			if (tick_ff && !(flag_ff && jolt_direction_ff != 2'b00)) begin // [R17]
				if (!armed_ff) begin
					if (over) begin
						armed_ff     <= 1'b1; // [R10]
						first_neg_ff <= perp[7];
						win_ff       <= 8'h00;
					end
				end else if (perp[7] != first_neg_ff && perp != 8'h00
					&& (reversal_mode || over)) begin // [R12]
					armed_ff          <= 1'b0;
					jolt_direction_ff <= first_neg_ff ? 2'b01 : 2'b10; // [R14]
					shake_hit_ff      <= 1'b1;
				end else if (win_ff + 8'h01 >= win_goal) begin
					armed_ff <= 1'b0; // [R13]
				end else begin
					win_ff <= win_ff + 8'h01;
				end
			end
		end
	end
	// ****************************************************************
	// interrupt flag; a new event beats a status read
	// ****************************************************************
	always @(posedge clk_sys or negedge rst_b_ff) begin
		if (!rst_b_ff) begin
			flag_ff <= 1'b0;
			irq_ff  <= 1'b0;
		end else begin
			if (facing_chg_ff || shake_hit_ff)
				flag_ff <= 1'b1; // [R15]
			else if (status_read)
				flag_ff <= 1'b0; // [R16] [R18]
			irq_ff <= flag_ff; // [R15]
		end
	end
endmodule // tsd_top
`default_nettype wire

// File: hdl/tsd_regs.vh
// constants of the tilt and shake detector: register map, fields, counts
// assumes a 10 MHz system clock and an I2C master on the far side
// Functional notes
// R1 - every register is eight bits; map holds x, y, status and control
// R2 - x and y readings are signed bytes from -128 to +127
// R3 - status: D7 flag, D6:D5 shake code, D4 weak, D3:D2 instant, D1:D0 filtered
// R4 - facing codes: 00 upright, 01 clockwise, 10 inverted, 11 counterclockwise
// R5 - facing from signs of x-y and x+y; valid if larger magnitude over 3/8 g
// R6 - filtered facing changes after 16/32/64/128 equal consecutive valid readings
// R7 - readings are taken at 100 per second; all counts are in readings
// R8 - instantaneous facing refreshes on every valid reading, unfiltered
// R9 - weak flag updated every reading: 0 valid, 1 invalid
// R10 - shake axis is x for facing 01/11, y for 00/10; starts above threshold
// R11 - threshold select: 0.5, 1.0, 1.5, 2.0 g
// R12 - mode 0 needs opposite crossing; mode 1 needs only a sign reversal
// R13 - second event within 16/32/64/128 readings of the first crossing
// R14 - shake code from signs: 01 left, 10 right, 00 none
// R15 - flag set on filtered facing change or shake; pin high while set
// R16 - reading status clears the flag
// R17 - after a shake, later shakes ignored until serviced; facing keeps updating
// R18 - host services the flag by reading status
// R19 - control: D7 power-down, D6 mode, D5:D4 threshold, D3:D2 window, D1:D0 settle
// R20 - power-down bit stops detection
// R21 - write: byte after address loads pointer; later bytes stored, pointer increments
// R22 - read: pointer written, repeated start, bytes returned with pointer increment
// R23 - unassigned addresses read zero; writes to them or read-only are ignored
// R24 - reset clears control, status fields and flag
`ifndef TSD_REGS_VH
`define TSD_REGS_VH
`define TSD_ADR_X        8'h00
`define TSD_ADR_Y        8'h01
`define TSD_ADR_STATUS   8'h02
`define TSD_ADR_CTRL     8'h04
`define TSD_ST_FLAG      7
`define TSD_ST_JOLT_HI   6
`define TSD_ST_JOLT_LO   5
`define TSD_ST_WEAK      4
`define TSD_ST_INST_HI   3
`define TSD_ST_INST_LO   2
`define TSD_ST_FILT_HI   1
`define TSD_ST_FILT_LO   0
`define TSD_CT_LOWPWR    7
`define TSD_CT_MODE      6
`define TSD_CT_TH_HI     5
`define TSD_CT_TH_LO     4
`define TSD_CT_WIN_HI    3
`define TSD_CT_WIN_LO    2
`define TSD_CT_SET_HI    1
`define TSD_CT_SET_LO    0
`define TSD_CTRL_RESET   8'h00
// bus address; the value is arbitrary
`define TSD_SLAVE_ADDR   7'h15
`define TSD_ONE_G        8'h40
`define TSD_VALID_MAG    8'h18
`define TSD_READ_RATE_HZ 100
`define TSD_CLK_HZ       10000000
`define TSD_READ_CYCLES  (`TSD_CLK_HZ / `TSD_READ_RATE_HZ)
// last count of the reading divider, one reading every 100000 clocks
`define TSD_READ_LAST    17'h1869F
`endif

// File: hdl/tsd_i2c_slave.v
// byte-level I2C slave: start/stop detection, address match, pointer and data bytes
// assumes scl and sda already passed two flip-flops on clk_sys
`timescale 1ns/1ns
`default_nettype none
`include "tsd_regs.vh"
module tsd_i2c_slave (
	// clock and reset
	input  wire       clk_sys,
	input  wire       rst_n_sync,
	// synchronised bus lines
	input  wire       scl_s,
	input  wire       sda_s,
	// sda drive, oe low while pulling low
	output reg        sda_oe_n_ff,
	// register side
	output reg  [7:0] ptr_ff,
	output reg        wr_stb_ff,
	output reg  [7:0] wr_data_ff,
	output reg        rd_stb_ff,
	input  wire [7:0] rd_data
);
	localparam ST_IDLE = 4'b0001;
	localparam ST_RX   = 4'b0010;
	localparam ST_ACK  = 4'b0100;
	localparam ST_TX   = 4'b1000;
	reg  [3:0] state_ff;
	reg        scl_d_ff;
	reg        sda_d_ff;
	reg  [7:0] shift_ff;
	reg  [3:0] bit_ff;
	reg  [1:0] byte_ff;
	reg        read_ff;
	reg        ack_out_ff;
	wire       scl_rise = scl_s & ~scl_d_ff;
	wire       scl_fall = ~scl_s & scl_d_ff;
	wire       start_c  = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
	wire       stop_c   = scl_s & scl_d_ff & ~sda_d_ff & sda_s;
	always @(posedge clk_sys or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			state_ff    <= ST_IDLE;
			scl_d_ff    <= 1'b1;
			sda_d_ff    <= 1'b1;
			shift_ff    <= 8'h00;
			bit_ff      <= 4'h0;
			byte_ff     <= 2'd0;
			read_ff     <= 1'b0;
			ack_out_ff  <= 1'b0;
			sda_oe_n_ff <= 1'b1;
			ptr_ff      <= 8'h00;
			wr_stb_ff   <= 1'b0;
			wr_data_ff  <= 8'h00;
			rd_stb_ff   <= 1'b0;
		end else begin
			scl_d_ff  <= scl_s;
			sda_d_ff  <= sda_s;
			wr_stb_ff <= 1'b0;
			rd_stb_ff <= 1'b0;
			if (start_c) begin
				state_ff    <= ST_RX;
				bit_ff      <= 4'h0;
				byte_ff     <= 2'd0;
				sda_oe_n_ff <= 1'b1;
			end else if (stop_c) begin
				state_ff    <= ST_IDLE;
				sda_oe_n_ff <= 1'b1;
			end else begin
				case (state_ff)
				ST_IDLE: begin
				end
				ST_RX: begin
					if (scl_rise) begin
						shift_ff <= {shift_ff[6:0], sda_s};
						bit_ff <= bit_ff + 4'h1;
					end
					if (scl_fall && bit_ff == 4'h8) begin
						bit_ff <= 4'h0;
						state_ff <= ST_ACK;
						ack_out_ff <= 1'b0;
						if (byte_ff == 2'd0) begin
							if (shift_ff[7:1] == `TSD_SLAVE_ADDR) begin
								sda_oe_n_ff <= 1'b0;
								read_ff     <= shift_ff[0];
							end else begin
								state_ff <= ST_IDLE;
							end
						end else if (byte_ff == 2'd1) begin
							sda_oe_n_ff <= 1'b0;
							ptr_ff      <= shift_ff; // [R21]
						end else begin
							sda_oe_n_ff <= 1'b0;
							wr_stb_ff   <= 1'b1; // [R21]
							wr_data_ff  <= shift_ff;
						end
					end
				end
				ST_ACK: begin
					// end of ninth clock: release, or load first read bit
					if (scl_fall) begin
						if (ack_out_ff) begin
							if (sda_d_ff) begin
								state_ff    <= ST_IDLE;
								sda_oe_n_ff <= 1'b1;
							end else begin
								state_ff    <= ST_TX;
								shift_ff    <= {rd_data[6:0], 1'b0};
								sda_oe_n_ff <= rd_data[7];
								rd_stb_ff   <= 1'b1; // [R22]
								bit_ff      <= 4'h1;
							end
						end else if (byte_ff >= 2'd1 || read_ff) begin
							if (byte_ff >= 2'd2)
								ptr_ff <= ptr_ff + 8'h01; // [R21]
							if (byte_ff != 2'd3)
								byte_ff <= byte_ff + 2'd1;
							if (read_ff) begin
								state_ff    <= ST_TX;
								shift_ff    <= {rd_data[6:0], 1'b0};
								sda_oe_n_ff <= rd_data[7];
								rd_stb_ff   <= 1'b1; // [R22]
								bit_ff      <= 4'h1;
							end else begin
								state_ff    <= ST_RX;
								sda_oe_n_ff <= 1'b1;
							end
						end else begin
							byte_ff     <= 2'd1;
							state_ff    <= ST_RX;
							sda_oe_n_ff <= 1'b1;
						end
					end
				end
				ST_TX: begin
					if (scl_fall) begin
						if (bit_ff == 4'h8) begin
							sda_oe_n_ff <= 1'b1;
							ptr_ff      <= ptr_ff + 8'h01; // [R22]
							ack_out_ff  <= 1'b1;
							state_ff    <= ST_ACK;
						end else begin
							sda_oe_n_ff <= shift_ff[7];
							shift_ff    <= {shift_ff[6:0], 1'b0};
							bit_ff      <= bit_ff + 4'h1;
						end
					end
				end
				default: state_ff <= ST_IDLE;
				endcase
			end
		end
	end
endmodule // tsd_i2c_slave
`default_nettype wire

// File: dv/tsd_top_chk.sv
// port checker for tsd_top: i2c pin behaviour, reset state, interrupt quiet time
// assumes it is bound to tsd_top; scl_in and sda_in are the resolved wire levels
`timescale 1ns/1ns
`default_nettype none
module tsd_top_chk (
	// clock and reset
	input wire logic       clk_sys,
	input wire logic       rst_n,
	// front end
	input wire logic [7:0] x_sample,
	input wire logic [7:0] y_sample,
	// i2c pins
	input wire logic       scl_in,
	input wire logic       sda_in,
	input wire logic       sda_oe_n,
	input wire logic       sda_out,
	// status pins
	input wire logic       irq_ff,
	input wire logic       low_power_ff
);
	// ****************
	// helper and rules
	// ****************
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	logic [16:0] since_rst_ff;
	// saturates so a long run never wraps into the quiet window again
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) since_rst_ff <= 17'h00000;
		else if (since_rst_ff != 17'h1FFFF) since_rst_ff <= since_rst_ff + 17'h00001;
	end
	property p_pull_only;
		sda_out == 1'b0;
	endproperty
	a_pull_only: assert property (p_pull_only) else $error("sda driven high");
	property p_reset_quiet;
		$rose(rst_n) |-> !irq_ff && !low_power_ff;
	endproperty
	a_reset_quiet: assert property (p_reset_quiet) else $error("irq or power set");
	property p_oe_reset;
		$rose(rst_n) |-> sda_oe_n [*3];
	endproperty
	a_oe_reset: assert property (p_oe_reset) else $error("sda pulled after reset");
	property p_change_scl_low;
		$changed(sda_oe_n) |-> !scl_in && !$past(scl_in, 2);
	endproperty
	a_change_scl_low: assert property (p_change_scl_low) else $error("sda moved, scl high");
	property p_lp_at_ack;
		$changed(low_power_ff) |-> ##[0:12] !sda_oe_n;
	endproperty
	a_lp_at_ack: assert property (p_lp_at_ack) else $error("power moved off a write");
	property p_ack_hold;
		$fell(sda_oe_n) |-> (!sda_oe_n) [*4];
	endproperty
	a_ack_hold: assert property (p_ack_hold) else $error("sda pull too short");
	property p_stop_release;
		scl_in && $past(scl_in) && $rose(sda_in) |-> sda_oe_n [*8];
	endproperty
	a_stop_release: assert property (p_stop_release) else $error("sda pulled after stop");
	property p_quiet_first;
		since_rst_ff < 17'h182B8 |-> !irq_ff;
	endproperty
	a_quiet_first: assert property (p_quiet_first) else $error("irq before a reading");
endmodule // tsd_top_chk
`default_nettype wire

// File: dv/tsd_host.sv
// i2c master model standing in for the host processor
// assumes clk_sys at 10 MHz; a bit takes 8 clk_sys (800 ns), scl idles high
`timescale 1ns/1ns
`default_nettype none
`include "tsd_regs.vh"
module tsd_host (
	// clock
	input  wire logic clk_sys,
	// bus
	input  wire logic sda_line,
	output var  logic scl,
	output var  logic sda_low
);
	// ***************
	// bus transfers
	// ***************
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	task automatic w(input int n);
		repeat (n) @(negedge clk_sys);
	endtask
	// long low phase: the slave answers several clocks after it sees scl fall
	task automatic start;
		w(1);
		sda_low = 1'b0;
		w(6);
		scl = 1'b1;
		w(4);
		sda_low = 1'b1;
		w(4);
		scl = 1'b0;
	endtask
	task automatic stop;
		w(1);
		sda_low = 1'b1;
		w(6);
		scl = 1'b1;
		w(4);
		sda_low = 1'b0;
		w(8);
	endtask
	task automatic bit_io(input logic b, output logic r);
		w(1);
		sda_low = !b;
		w(5);
		scl = 1'b1;
		w(2);
		r = sda_line;
		scl = 1'b0;
	endtask
	task automatic put(input logic [7:0] b, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(b[i], r);
		bit_io(1'b1, r);
		ack = !r;
	endtask
	task automatic get(input logic last, output logic [7:0] b);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, r);
			b[i] = r;
		end
		bit_io(last, r);
	endtask
	task automatic probe(input logic [6:0] a, output logic ok);
		start();
		put({a, 1'b0}, ok);
		stop();
	endtask
	// pointer byte, then n data bytes, upper byte first
	task automatic wr(input logic [7:0] p, input logic [15:0] d, input int n, output logic ok);
		logic a;
		start();
		put({`TSD_SLAVE_ADDR, 1'b0}, ok);
		put(p, a);
		ok &= a;
		for (int i = n - 1; i >= 0; i--) begin
			put(d[8*i +: 8], a);
			ok &= a;
		end
		stop();
	endtask
	// pointer, repeated start, n bytes; the last byte is left unacked
	task automatic rd(input logic [7:0] p, input int n, output logic [23:0] v, output logic ok);
		logic a;
		logic [7:0] b;
		v = 24'h000000;
		start();
		put({`TSD_SLAVE_ADDR, 1'b0}, ok);
		put(p, a);
		ok &= a;
		start();
		put({`TSD_SLAVE_ADDR, 1'b1}, a);
		ok &= a;
		for (int i = n - 1; i >= 0; i--) begin
			get(i == 0, b);
			v[8*i +: 8] = b;
		end
		stop();
	endtask
endmodule // tsd_host
`default_nettype wire

// File: dv/tsd_top_test.sv
// self-checking bench for tsd_top with an i2c host model
// assumes one reading tick per 100000 clk_sys; the run covers the first one
`timescale 1ns/1ns
`default_nettype none
`include "tsd_regs.vh"
module tsd_top_test;
	// ***************
	// harness
	// ***************
	logic       clk_sys = 1'b0;
	logic       rst_n = 1'b0;
	logic [7:0] x_sample = 8'hE8;
	logic [7:0] y_sample = 8'h18;
	wire        scl;
	wire        sda_low;
	wire        sda_oe_n;
	wire        sda_out;
	wire        irq_ff;
	wire        low_power_ff;
	// pulled-up open-drain line
	wire        sda_line = !sda_low && (sda_oe_n || sda_out);
	int         n_mismatch = 0;
	int         checked = 0;
	int         cyc = 0;
	logic       ok;
	logic [23:0] v;
	always #50 clk_sys = ~clk_sys;
	always @(posedge clk_sys) cyc <= cyc + 1;
	tsd_top i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .x_sample(x_sample), .y_sample(y_sample),
		.scl_in(scl), .sda_in(sda_line), .sda_oe_n(sda_oe_n), .sda_out(sda_out),
		.irq_ff(irq_ff), .low_power_ff(low_power_ff));
	tsd_host i_host (.clk_sys(clk_sys), .sda_line(sda_line), .scl(scl), .sda_low(sda_low));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic summarize;
		$display("checks %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	// ***************
	// scenarios
	// ***************
	task automatic t_reset;
		i_host.rd(`TSD_ADR_STATUS, 1, v, ok);
		chk(v[7:0], 8'h00);
		chk({5'h00, ok, irq_ff, low_power_ff}, 8'h04);
	endtask
	task automatic t_refuse;
		i_host.probe(`TSD_SLAVE_ADDR ^ 7'h01, ok);
		chk({7'h00, ok}, 8'h00);
		i_host.rd(`TSD_ADR_STATUS, 2, v, ok);
		chk(v[15:8], 8'h00);
		chk(v[7:0], 8'h00);
		i_host.rd(8'h05, 2, v, ok);
		chk(v[15:8], 8'h00);
		chk(v[7:0], 8'h00);
	endtask
	// samples sit exactly on the 3/8 g bound, so the reading must count as weak
	task automatic t_reading;
		for (int i = 0; i < 120000 && cyc < 100600; i++) @(negedge clk_sys);
		if (cyc < 100600) n_mismatch++; // wait ran out
		i_host.wr(`TSD_ADR_X, 16'h00FF, 1, ok);
		i_host.rd(`TSD_ADR_X, 3, v, ok);
		chk(v[23:16], 8'hE8);
		chk(v[15:8], 8'h18);
		chk(v[7:0], 8'h10);
		chk({7'h00, irq_ff}, 8'h00);
	endtask
	task automatic t_ctrl;
		i_host.wr(8'h03, 16'h5580, 2, ok);
		chk({7'h00, ok}, 8'h01);
		chk({7'h00, low_power_ff}, 8'h01);
		i_host.rd(8'h03, 1, v, ok);
		chk(v[7:0], 8'h00);
		i_host.wr(`TSD_ADR_CTRL, 16'h0000, 1, ok);
		chk({7'h00, low_power_ff}, 8'h00);
	endtask
	// a mid-run reset must drop power-down and the weak flag left by the reading
	task automatic t_reset_again;
		i_host.wr(`TSD_ADR_CTRL, 16'h0080, 1, ok);
		chk({7'h00, low_power_ff}, 8'h01);
		@(negedge clk_sys);
		rst_n = 1'b0;
		repeat (2) @(negedge clk_sys);
		rst_n = 1'b1;
		chk({6'h00, irq_ff, low_power_ff}, 8'h00);
		repeat (4) @(negedge clk_sys);
		i_host.rd(`TSD_ADR_STATUS, 1, v, ok);
		chk(v[7:0], 8'h00);
		chk({7'h00, ok}, 8'h01);
	endtask
	initial begin
		repeat (2) @(negedge clk_sys);
		rst_n = 1'b1;
		repeat (4) @(negedge clk_sys);
		t_reset();
		t_refuse();
		t_reading();
		t_ctrl();
		t_reset_again();
		summarize();
	end
	initial begin
		repeat (130000) @(posedge clk_sys);
		n_mismatch++;
		summarize();
	end
endmodule // tsd_top_test
bind tsd_top tsd_top_chk i_chk (.clk_sys(clk_sys), .rst_n(rst_n), .x_sample(x_sample),
	.y_sample(y_sample), .scl_in(scl_in), .sda_in(sda_in), .sda_oe_n(sda_oe_n),
	.sda_out(sda_out), .irq_ff(irq_ff), .low_power_ff(low_power_ff));
`default_nettype wire
